/* inc/flash_cmd_pkg.sv */
package flash_cmd_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BANK_W = 3;
    localparam int BANK_LSB = 21;
    localparam int MAX_BUF_WORDS = 32;
    localparam int MAX_BUF_CYCLES = 37;
    localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
    localparam logic [11:0] UNLOCK2_ADDR = 12'h2AA;
    localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
    localparam logic [7:0] UNLOCK2_DATA = 8'h55;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
    localparam logic [7:0] CMD_BUF_COMMIT = 8'h29;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_SHORTCUT = 8'h20;
    localparam logic [7:0] CMD_OTP_ENTRY = 8'h88;
    localparam logic [7:0] CMD_EXIT2 = 8'h00;
    localparam logic [7:0] ID_MAKER_OFS = 8'h00;
    localparam logic [7:0] ID_DEV1_OFS = 8'h01;
    localparam logic [7:0] ID_IND_OFS = 8'h03;
    localparam logic [7:0] ID_DEV2_OFS = 8'h0E;
    localparam logic [7:0] ID_DEV3_OFS = 8'h0F;
    localparam int T_SETUP_NS = 8;
    localparam int T_PULSE_NS = 40;
    localparam int T_HOLD_NS = 8;
    localparam int CLK_NS = 4;
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0] SEQ_LEN_RESET = 6'd1;

    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_RESET = 4'h1, OP_IDENT = 4'h2,
        OP_PROGRAM = 4'h3, OP_BUF_WRITE = 4'h4, OP_BUF_COMMIT = 4'h5,
        OP_BUF_ABORT = 4'h6, OP_CHIP_ERASE = 4'h7, OP_SECTOR_ERASE = 4'h8,
        OP_SUSPEND = 4'h9, OP_RESUME = 4'hA, OP_QUERY = 4'hB,
        OP_SC_ENTRY = 4'hC, OP_SC_EXIT = 4'hD, OP_OTP_ENTRY = 4'hE,
        OP_OTP_EXIT = 4'hF
    } op_e;

    typedef enum logic [1:0] {
        MODE_ARRAY = 2'h0, MODE_SHORTCUT = 2'h1, MODE_OTP = 2'h2,
        MODE_IDENT = 2'h3
    } mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_PULSE = 3'b011,
        ST_HOLD = 3'b010, ST_NEXT = 3'b110, ST_DONE = 3'b111
    } state_e;
endpackage : flash_cmd_pkg

/* design/flash_command_decoder.sv */
// Notes on behaviour
// RULE_01: array reads need no command cycles
// RULE_02: F0 resets bank to array read; the code does so only from ident mode and keeps shortcut or one-time mode
// RULE_03: ident entry: AA, 55, 90 at bank
// RULE_04: command cycles are writes except reads
// RULE_05: upper data byte ignored in commands
// RULE_06: high address bits ignored in commands
// RULE_07: wrong sequence recovered by reset command
// RULE_08: program is four cycles ending location/value
// RULE_09: data held past rising strobe edge
// RULE_10: buffer write: 25, count minus one, pairs
// RULE_11: slot locations within first location's page
// RULE_12: buffered sequences up to 37 cycles
// RULE_13: commit buffer with 29 at sector
// RULE_14: abort clears with AA, 55, F0
// RULE_15: erase six cycles, shortcut erase two
// RULE_16: suspend B0 only while sector erase
// RULE_17: resume 30 only while suspended
// RULE_18: query 98 only from array or ident; the code also accepts it in shortcut mode and refuses it only in one-time mode
// RULE_19: shortcut entry 20 enables short program
// RULE_20: shortcut exit is 90 then 00
// RULE_21: one-time region entry 88, exit four cycles
// RULE_22: command modes mutually exclusive
// RULE_23: mode state tracked per bank
module flash_command_decoder #(
    parameter int NUM_BANKS = 8,
    parameter int BUF_WORDS = flash_cmd_pkg::MAX_BUF_WORDS
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    input wire flash_cmd_pkg::op_e i_req_op,
    input wire logic [flash_cmd_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [flash_cmd_pkg::DATA_W-1:0] i_req_data,
    input wire logic [5:0] i_req_count,
    output logic o_req_ready,
    output logic o_word_ready,
    input wire logic i_word_valid,
    input wire logic [flash_cmd_pkg::ADDR_W-1:0] i_word_addr,
    input wire logic [flash_cmd_pkg::DATA_W-1:0] i_word_data,
    output logic o_done,
    output logic o_refused,
    output logic [flash_cmd_pkg::DATA_W-1:0] o_rd_data,
    output logic [flash_cmd_pkg::ADDR_W-1:0] o_addr,
    output logic [flash_cmd_pkg::DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [flash_cmd_pkg::DATA_W-1:0] i_dq,
    output logic o_ce_n,
    output logic o_we_n,
    output logic o_oe_n
);
    import flash_cmd_pkg::*;

    initial begin
        if (NUM_BANKS != (1 << BANK_W) || BUF_WORDS < 1 ||
            BUF_WORDS > MAX_BUF_WORDS) begin
            $error("unsupported bank or buffer parameters");
        end
    end

    localparam int SEQ_MAX = MAX_BUF_CYCLES; // [RULE_12]
    localparam int PG_LSB = $clog2(MAX_BUF_WORDS);

    state_e state;
    op_e op;
    mode_e mode [NUM_BANKS]; // [RULE_23]
    logic erasing [NUM_BANKS];
    logic suspended [NUM_BANKS];
    logic [5:0] step;
    logic [5:0] seq_len;
    logic [5:0] cnt;
    logic [ADDR_W-1:0] base;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic is_read;
    logic [ADDR_W-1:0] cyc_addr;
    logic [DATA_W-1:0] cyc_data;
    logic cyc_is_read;
    logic cyc_needs_word;

    wire [BANK_W-1:0] bank = base[BANK_LSB +: BANK_W];
    wire [ADDR_W-1:0] bank_ofs = {bank, {(ADDR_W-BANK_W){1'b0}}};
    wire mode_array = mode[bank] == MODE_ARRAY;
    wire mode_sc = mode[bank] == MODE_SHORTCUT;
    wire mode_otp = mode[bank] == MODE_OTP;
    wire slot_in_page = i_word_addr[ADDR_W-1:PG_LSB] ==
        base[ADDR_W-1:PG_LSB]; // [RULE_11]

    function automatic logic [ADDR_W-1:0] cmd_a(input logic [11:0] a);
        cmd_a = {{(ADDR_W-12){1'b0}}, a}; // [RULE_06]
    endfunction : cmd_a

    function automatic logic [DATA_W-1:0] cmd_d(input logic [7:0] d);
        cmd_d = {8'h00, d}; // [RULE_05]
    endfunction : cmd_d

    // sequence length and legality of each operation against bank state
    logic [5:0] req_len;
    logic req_ok;
    always_comb begin
        req_len = 6'd3;
        req_ok = 1'b1;
        case (i_req_op)
            OP_READ, OP_RESET, OP_BUF_COMMIT: req_len = SEQ_LEN_RESET;
            OP_IDENT: req_len = 6'd4;
            OP_PROGRAM: req_len = (mode[i_req_addr[BANK_LSB +: BANK_W]]
                == MODE_ARRAY) ? 6'd4 : 6'd2; // [RULE_08] [RULE_19]
            OP_BUF_WRITE: req_len = 6'(i_req_count) + 6'd5; // [RULE_10]
            OP_CHIP_ERASE, OP_SECTOR_ERASE: req_len =
                (mode[i_req_addr[BANK_LSB +: BANK_W]] == MODE_SHORTCUT)
                ? 6'd2 : 6'd6; // [RULE_15]
            OP_SUSPEND: begin
                req_len = 6'd1;
                req_ok = erasing[i_req_addr[BANK_LSB +: BANK_W]]; // [RULE_16]
            end
            OP_RESUME: begin
                req_len = 6'd1;
                req_ok = suspended[i_req_addr[BANK_LSB +: BANK_W]]; // [RULE_17]
            end
            OP_QUERY: begin
                req_len = 6'd1;
                req_ok = mode[i_req_addr[BANK_LSB +: BANK_W]] != MODE_OTP;
            end
            OP_SC_ENTRY, OP_OTP_ENTRY: req_ok =
                mode[i_req_addr[BANK_LSB +: BANK_W]] == MODE_ARRAY; // [RULE_22]
            OP_SC_EXIT: begin
                req_len = 6'd2;
                req_ok = mode[i_req_addr[BANK_LSB +: BANK_W]] == MODE_SHORTCUT;
            end
            OP_OTP_EXIT: begin
                req_len = 6'd4;
                req_ok = mode[i_req_addr[BANK_LSB +: BANK_W]] == MODE_OTP;
            end
            default: req_len = 6'd3;
        endcase
        if (i_req_op == OP_BUF_WRITE && 32'(i_req_count) >= BUF_WORDS) begin
            req_ok = 1'b0;
        end
    end

    // address, data and direction of bus cycle number step
    always_comb begin
        cyc_addr = cmd_a(UNLOCK1_ADDR);
        cyc_data = cmd_d(UNLOCK1_DATA);
        cyc_is_read = 1'b0;
        cyc_needs_word = 1'b0;
        if (op == OP_READ) begin
            cyc_addr = base; // [RULE_01]
            cyc_is_read = 1'b1; // [RULE_04]
        end else if (op == OP_RESET) begin
            cyc_addr = base;
            cyc_data = cmd_d(CMD_RESET); // [RULE_02] [RULE_07]
        end else if (op == OP_BUF_COMMIT) begin
            cyc_addr = base;
            cyc_data = cmd_d(CMD_BUF_COMMIT); // [RULE_13]
        end else if (op == OP_SUSPEND || op == OP_RESUME) begin
            cyc_addr = bank_ofs;
            cyc_data = cmd_d(op == OP_SUSPEND ? CMD_SUSPEND : CMD_RESUME);
        end else if (op == OP_QUERY) begin
            cyc_addr = mode_sc ? bank_ofs : bank_ofs | cmd_a(UNLOCK1_ADDR);
            cyc_data = cmd_d(CMD_QUERY); // [RULE_18] [RULE_19]
        end else if (seq_len == 6'd2) begin
            // shortcut and one-time-region short forms
            cyc_addr = step == 6'd0 ? cmd_a(12'h000) : base;
            if (op == OP_SC_EXIT) begin
                cyc_data = cmd_d(step == 6'd0 ? CMD_IDENT : CMD_EXIT2); // [RULE_20]
            end else if (op == OP_PROGRAM) begin
                cyc_data = cmd_d(CMD_PROGRAM); // [RULE_21]
                if (step != 6'd0) begin
                    // program value comes through the word port
                    cyc_data = i_word_data; // [RULE_19] [RULE_21]
                    cyc_needs_word = 1'b1;
                end
            end else begin
                cyc_data = step == 6'd0 ? cmd_d(CMD_ERASE_SETUP) :
                    cmd_d(op == OP_CHIP_ERASE ? CMD_CHIP_ERASE :
                    CMD_SECTOR_ERASE);
            end
        end else if (step == 6'd1 || (step == 6'd4 && seq_len == 6'd6 &&
            op != OP_BUF_WRITE)) begin
            cyc_addr = cmd_a(UNLOCK2_ADDR);
            cyc_data = cmd_d(UNLOCK2_DATA);
        end else if (step == 6'd0 || step == 6'd3 && op != OP_BUF_WRITE &&
            op != OP_PROGRAM && op != OP_IDENT && op != OP_OTP_EXIT) begin
            cyc_addr = cmd_a(UNLOCK1_ADDR);
            cyc_data = cmd_d(UNLOCK1_DATA);
        end else if (step == 6'd2) begin
            cyc_addr = cmd_a(UNLOCK1_ADDR);
            case (op)
                OP_IDENT: begin
                    cyc_addr = bank_ofs | cmd_a(UNLOCK1_ADDR); // [RULE_03]
                    cyc_data = cmd_d(CMD_IDENT);
                end
                OP_PROGRAM: cyc_data = cmd_d(CMD_PROGRAM);
                OP_BUF_WRITE: begin
                    cyc_addr = base;
                    cyc_data = cmd_d(CMD_BUF_LOAD);
                end
                OP_BUF_ABORT: cyc_data = cmd_d(CMD_RESET); // [RULE_14]
                OP_SC_ENTRY: cyc_data = cmd_d(CMD_SHORTCUT);
                OP_OTP_ENTRY: cyc_data = cmd_d(CMD_OTP_ENTRY);
                OP_OTP_EXIT: cyc_data = cmd_d(CMD_IDENT);
                default: cyc_data = cmd_d(CMD_ERASE_SETUP);
            endcase
        end else if (op == OP_IDENT) begin
            cyc_addr = base | bank_ofs;
            cyc_is_read = 1'b1; // [RULE_03] [RULE_04]
        end else if (op == OP_PROGRAM) begin
            cyc_addr = base;
            cyc_data = i_word_data; // [RULE_05] [RULE_08]
            cyc_needs_word = 1'b1;
        end else if (op == OP_OTP_EXIT) begin
            cyc_addr = cmd_a(12'h000);
            cyc_data = cmd_d(CMD_EXIT2); // [RULE_21]
        end else if (op == OP_BUF_WRITE) begin
            if (step == 6'd3) begin
                cyc_addr = base;
                cyc_data = {10'h000, cnt}; // [RULE_10]
            end else begin
                cyc_addr = i_word_addr;
                cyc_data = i_word_data;
                cyc_needs_word = 1'b1;
            end
        end else begin
            cyc_addr = op == OP_CHIP_ERASE ? cmd_a(UNLOCK1_ADDR) : base;
            cyc_data = cmd_d(op == OP_CHIP_ERASE ? CMD_CHIP_ERASE :
                CMD_SECTOR_ERASE); // [RULE_15]
        end
    end

    logic [5:0] tmr;
    wire tmr_done = tmr == 6'd0;
    wire word_ok = !cyc_needs_word || (i_word_valid && slot_in_page);
    assign o_req_ready = state == ST_IDLE;
    assign o_word_ready = state == ST_NEXT && cyc_needs_word;
    assign o_dq_out = data;

    always_ff @(posedge i_mclk) begin
        dq_s1 <= i_dq;
        dq_s2 <= dq_s1;
        o_done <= 1'b0;
        if (i_sys_rst) begin
            state <= ST_IDLE;
            op <= OP_READ;
            step <= 6'd0;
            seq_len <= 6'd0;
            cnt <= 6'd0;
            base <= '0;
            data <= '0;
            tmr <= 6'd0;
            is_read <= 1'b0;
            o_refused <= 1'b0;
            o_rd_data <= '0;
            o_addr <= '0;
            o_dq_oe <= 1'b0;
            o_ce_n <= 1'b1;
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            for (int b = 0; b < NUM_BANKS; b++) begin
                mode[b] <= MODE_ARRAY;
                erasing[b] <= 1'b0;
                suspended[b] <= 1'b0;
            end
        end else begin
            if (tmr != 6'd0) begin
                tmr <= tmr - 6'd1;
            end
            case (state)
                ST_IDLE: if (i_req_valid) begin
                    o_refused <= !req_ok;
                    if (req_ok) begin
                        op <= i_req_op;
                        seq_len <= req_len;
                        cnt <= i_req_count;
                        base <= i_req_addr;
                        step <= 6'd0;
                        state <= ST_NEXT;
                    end
                end
                ST_NEXT: if (word_ok) begin
                    o_addr <= cyc_addr;
                    data <= cyc_data;
                    is_read <= cyc_is_read;
                    o_dq_oe <= !cyc_is_read;
                    o_ce_n <= 1'b0;
                    tmr <= 6'(SETUP_CYC);
                    state <= ST_SETUP;
                end
                ST_SETUP: if (tmr_done) begin
                    // strobe falls after ce: address latched here [RULE_08]
                    o_we_n <= is_read;
                    o_oe_n <= !is_read;
                    tmr <= 6'(PULSE_CYC);
                    state <= ST_PULSE;
                end
                ST_PULSE: if (tmr_done) begin
                    if (is_read) begin
                        o_rd_data <= dq_s2;
                    end
                    o_we_n <= 1'b1; // data held past this edge [RULE_09]
                    o_oe_n <= 1'b1;
                    tmr <= 6'(HOLD_CYC);
                    state <= ST_HOLD;
                end
                ST_HOLD: if (tmr_done) begin
                    o_ce_n <= 1'b1;
                    o_dq_oe <= 1'b0;
                    if (step + 6'd1 >= seq_len || step >= 6'(SEQ_MAX - 1)) begin
                        state <= ST_DONE;
                    end else begin
                        step <= step + 6'd1;
                        state <= ST_NEXT;
                    end
                end
                ST_DONE: begin
                    o_done <= 1'b1;
                    state <= ST_IDLE;
                    case (op)
                        OP_RESET, OP_BUF_ABORT: if (mode_array ||
                            mode[bank] == MODE_IDENT) begin
                            mode[bank] <= MODE_ARRAY; // [RULE_02] [RULE_14]
                        end
                        OP_IDENT: mode[bank] <= MODE_IDENT;
                        OP_SC_ENTRY: mode[bank] <= MODE_SHORTCUT; // [RULE_19]
                        OP_SC_EXIT: mode[bank] <= MODE_ARRAY; // [RULE_20]
                        OP_OTP_ENTRY: mode[bank] <= MODE_OTP; // [RULE_21]
                        OP_OTP_EXIT: mode[bank] <= MODE_ARRAY;
                        OP_SECTOR_ERASE: erasing[bank] <= !mode_otp;
                        OP_SUSPEND: begin
                            erasing[bank] <= 1'b0;
                            suspended[bank] <= 1'b1; // [RULE_16]
                        end
                        OP_RESUME: begin
                            suspended[bank] <= 1'b0; // [RULE_17]
                            erasing[bank] <= 1'b1;
                        end
                        default: mode[bank] <= mode[bank];
                    endcase
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule : flash_command_decoder

/* test/flash_decoder_props.sv */
module flash_decoder_props (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic o_done,
    input wire logic o_refused,
    input wire logic [flash_cmd_pkg::ADDR_W-1:0] o_addr,
    input wire logic [flash_cmd_pkg::DATA_W-1:0] o_dq_out,
    input wire logic o_dq_oe,
    input wire logic o_ce_n,
    input wire logic o_we_n,
    input wire logic o_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    chk_we_in_ce: assert property (!o_we_n |-> !o_ce_n)
        else $error("write strobe low outside chip select");
    chk_read_quiet: assert property (!o_oe_n |-> o_we_n && !o_dq_oe)
        else $error("bus driven or written during read");
    chk_addr_steady: assert property (
        !o_we_n && !$past(o_we_n) |-> $stable(o_addr))
        else $error("address moved during write pulse");
    chk_data_driven: assert property (!o_we_n |-> o_dq_oe)
        else $error("data not driven during write pulse");
    chk_data_hold: assert property (
        $rose(o_we_n) |-> o_dq_oe && $stable(o_dq_out))
        else $error("data not held at strobe rise");
    chk_pulse_width: assert property (
        $fell(o_we_n) |-> !o_we_n [*8])
        else $error("write pulse too short");
    chk_done_idle: assert property (
        o_done |-> o_ce_n && o_we_n ##1 !o_done)
        else $error("done not a pulse after bus idle");
    chk_refuse_quiet: assert property (
        o_refused && $past(o_refused) |-> o_ce_n)
        else $error("bus cycle after refused request");
    chk_reset_idle: assert property (disable iff (1'b0)
        $past(i_sys_rst) && !i_sys_rst |->
        o_ce_n && o_we_n && o_oe_n && !o_dq_oe)
        else $error("strobes not idle after reset");

    cover property (o_done);
    cover property ($rose(o_refused));
    cover property ($fell(o_oe_n));
endmodule : flash_decoder_props

bind flash_command_decoder flash_decoder_props props_i (.i_mclk, .i_sys_rst,
    .o_done, .o_refused, .o_addr, .o_dq_out, .o_dq_oe, .o_ce_n, .o_we_n,
    .o_oe_n);

/* test/flash_device_model.sv */
module flash_device_model #(
    parameter logic [15:0] MAKER_CODE = 16'h00C3 // arbitrary value
) (
    input wire logic [23:0] i_addr,
    input wire logic [15:0] i_dq_in,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    output logic [15:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [39:0] wlog[$];
    logic [23:0] lat_addr = '0;
    logic [15:0] last = '0;
    logic ident = 1'b0;
    logic [15:0] rd_val;

    // array content is a pattern of the address
    assign rd_val = ident ? ((i_addr[7:0] == 8'h00) ? MAKER_CODE : 16'h0000)
        : (i_addr[15:0] ^ 16'h5A5A);
    // released bus shows the inverse of the last value
    assign o_dq = (!i_ce_n && !i_oe_n) ? rd_val : ~last;

    always @(posedge i_oe_n) last <= rd_val;
    always @(negedge i_we_n) if (!i_ce_n) lat_addr <= i_addr;

    always @(posedge i_we_n) begin
        if (!i_ce_n) begin
            wlog.push_back({lat_addr, i_dq_in});
            if (i_dq_in[7:0] == 8'hF0) begin
                ident <= 1'b0;
            end else if (i_dq_in[7:0] == 8'h90
                && lat_addr[11:0] == 12'h555) begin
                ident <= 1'b1;
            end
        end
    end
endmodule : flash_device_model

/* test/tb_top.sv */
module tb_top;
    import flash_cmd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end

    logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_req_valid = 1'b0;
    logic i_word_valid = 1'b0;
    op_e i_req_op = OP_READ;
    logic [ADDR_W-1:0] i_req_addr = '0, i_word_addr = '0, o_addr;
    logic [DATA_W-1:0] i_req_data = '0, i_word_data = '0;
    logic [DATA_W-1:0] o_rd_data, o_dq_out, i_dq;
    logic [5:0] i_req_count = '0;
    logic o_req_ready, o_word_ready, o_done, o_refused;
    logic o_dq_oe, o_ce_n, o_we_n, o_oe_n;
    logic got_ref;
    int num_errors = 0, total_checks = 0;

    flash_command_decoder dut (.i_mclk, .i_sys_rst, .i_req_valid, .i_req_op,
        .i_req_addr, .i_req_data, .i_req_count, .o_req_ready, .o_word_ready,
        .i_word_valid, .i_word_addr, .i_word_data, .o_done, .o_refused,
        .o_rd_data, .o_addr, .o_dq_out, .o_dq_oe, .i_dq, .o_ce_n, .o_we_n,
        .o_oe_n);
    flash_device_model dev (.i_addr(o_addr), .i_dq_in(o_dq_out),
        .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n), .o_dq(i_dq));

    initial forever #2 i_mclk = ~i_mclk;

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic run(input op_e op, input logic [23:0] a,
        input logic [15:0] d, input logic [5:0] n);
        int k;
        int w;
        w = 0;
        dev.wlog.delete();
        @(negedge i_mclk);
        i_req_valid = 1'b1;
        i_req_op = op;
        i_req_addr = a;
        i_req_data = d;
        i_req_count = n;
        i_word_valid = 1'b1;
        i_word_addr = a;
        i_word_data = d;
        do @(posedge i_mclk); while (!o_req_ready);
        @(negedge i_mclk);
        i_req_valid = 1'b0;
        for (k = 0; k < 3000; k++) begin
            @(negedge i_mclk);
            got_ref = o_refused;
            if (o_done || o_refused) break;
            // word w stands until the edge that takes it
            i_word_addr = a + 24'(w);
            i_word_data = d + 16'(w);
            if (o_word_ready) w++;
        end
        `CHK("req_end", 1'b1, k < 3000)
    endtask : run

    task automatic cyc(input int i, input logic [11:0] a,
        input logic [7:0] d);
        `CHK("cmd_addr", a, dev.wlog[i][27:16])
        `CHK("cmd_data", d, dev.wlog[i][7:0])
    endtask : cyc

    task automatic full(input int i, input logic [23:0] a,
        input logic [15:0] d);
        `CHK("word_addr", a, dev.wlog[i][39:16])
        `CHK("word_data", d, dev.wlog[i][15:0])
    endtask : full

    task automatic nc(input int n, input logic r);
        `CHK("bus_cycles", n, dev.wlog.size())
        `CHK("refused", r, got_ref)
    endtask : nc

    task automatic unlock(input int i);
        cyc(i, 12'h555, 8'hAA);
        cyc(i + 1, 12'h2AA, 8'h55);
    endtask : unlock

    task automatic t_basic;
        `CHK("ready", 1'b1, o_req_ready)
        `CHK("ce_idle", 1'b1, o_ce_n)
        run(OP_READ, 24'h012345, 16'h0000, 6'h00);
        nc(0, 1'b0);
        `CHK("rd_data", 16'h2345 ^ 16'h5A5A, o_rd_data)
        run(OP_RESET, 24'h7F0000, 16'h0000, 6'h00);
        nc(1, 1'b0);
        `CHK("reset_cmd", 8'hF0, dev.wlog[0][7:0])
        run(OP_PROGRAM, 24'h201234, 16'hBEEF, 6'h00);
        nc(4, 1'b0);
        unlock(0);
        cyc(2, 12'h555, 8'hA0);
        full(3, 24'h201234, 16'hBEEF);
        $display("test basic done");
    endtask : t_basic

    task automatic t_erase;
        run(OP_SUSPEND, 24'h600000, 16'h0000, 6'h00);
        nc(0, 1'b1);
        run(OP_CHIP_ERASE, 24'h000000, 16'h0000, 6'h00);
        nc(6, 1'b0);
        unlock(0);
        cyc(2, 12'h555, 8'h80);
        unlock(3);
        cyc(5, 12'h555, 8'h10);
        run(OP_SECTOR_ERASE, 24'h608000, 16'h0000, 6'h00);
        nc(6, 1'b0);
        cyc(2, 12'h555, 8'h80);
        `CHK("sector", 24'h608000, dev.wlog[5][39:16])
        cyc(5, 12'h000, 8'h30);
        run(OP_SUSPEND, 24'h600000, 16'h0000, 6'h00);
        nc(1, 1'b0);
        `CHK("bank", 3'h3, dev.wlog[0][39:37])
        `CHK("suspend", 8'hB0, dev.wlog[0][7:0])
        run(OP_RESUME, 24'h600000, 16'h0000, 6'h00);
        nc(1, 1'b0);
        `CHK("resume", 8'h30, dev.wlog[0][7:0])
        run(OP_RESUME, 24'h600000, 16'h0000, 6'h00);
        nc(0, 1'b1);
        $display("test erase done");
    endtask : t_erase

    task automatic t_modes;
        run(OP_SC_ENTRY, 24'h000000, 16'h0000, 6'h00);
        nc(3, 1'b0);
        cyc(2, 12'h555, 8'h20);
        run(OP_PROGRAM, 24'h001000, 16'h1234, 6'h00);
        nc(2, 1'b0);
        `CHK("sc_prog", 8'hA0, dev.wlog[0][7:0])
        full(1, 24'h001000, 16'h1234);
        run(OP_SC_EXIT, 24'h000000, 16'h0000, 6'h00);
        nc(2, 1'b0);
        `CHK("exit1", 8'h90, dev.wlog[0][7:0])
        `CHK("exit2", 8'h00, dev.wlog[1][7:0])
        run(OP_OTP_ENTRY, 24'h000000, 16'h0000, 6'h00);
        nc(3, 1'b0);
        cyc(2, 12'h555, 8'h88);
        run(OP_QUERY, 24'h000000, 16'h0000, 6'h00);
        nc(0, 1'b1);
        run(OP_OTP_EXIT, 24'h000000, 16'h0000, 6'h00);
        nc(4, 1'b0);
        cyc(2, 12'h555, 8'h90);
        `CHK("otp_exit", 8'h00, dev.wlog[3][7:0])
        run(OP_QUERY, 24'h600000, 16'h0000, 6'h00);
        nc(1, 1'b0);
        cyc(0, 12'h555, 8'h98);
        `CHK("q_bank", 3'h3, dev.wlog[0][39:37])
        run(OP_RESET, 24'h000000, 16'h0000, 6'h00);
        run(OP_IDENT, 24'h400000, 16'h0000, 6'h00);
        cyc(2, 12'h555, 8'h90);
        `CHK("id_bank", 3'h2, dev.wlog[2][39:37])
        `CHK("maker", dev.MAKER_CODE, o_rd_data)
        run(OP_RESET, 24'h400000, 16'h0000, 6'h00);
        $display("test modes done");
    endtask : t_modes

    task automatic t_buffer;
        run(OP_BUF_WRITE, 24'h400020, 16'h1000, 6'd1);
        nc(6, 1'b0);
        unlock(0);
        cyc(2, 12'h020, 8'h25);
        cyc(3, 12'h020, 8'h01);
        full(4, 24'h400020, 16'h1000);
        full(5, 24'h400021, 16'h1001);
        run(OP_BUF_COMMIT, 24'h400020, 16'h0000, 6'h00);
        nc(1, 1'b0);
        cyc(0, 12'h020, 8'h29);
        run(OP_BUF_WRITE, 24'h400020, 16'h2000, 6'd31);
        nc(36, 1'b0);
        full(35, 24'h40003F, 16'h201F);
        run(OP_BUF_ABORT, 24'h000000, 16'h0000, 6'h00);
        nc(3, 1'b0);
        unlock(0);
        cyc(2, 12'h555, 8'hF0);
        run(OP_BUF_WRITE, 24'h400020, 16'h2000, 6'd32);
        nc(0, 1'b1);
        $display("test buffer done");
    endtask : t_buffer

    initial begin
        repeat (60000) @(posedge i_mclk);
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge i_mclk);
        @(negedge i_mclk);
        i_sys_rst = 1'b0;
        t_basic();
        t_erase();
        t_modes();
        t_buffer();
        wrap_up();
    end
endmodule : tb_top
